// ==== dehy_defines.svh ====
`ifndef DEHY_DEFINES_SVH
`define DEHY_DEFINES_SVH

// clock and time base
`define CLK_HZ 50000000
`define TEST_CYC 50000000
`define HP_PERSIST_S 30
// 2.5 h soak, 6 h cooling, 200 h in service, all in seconds
`define SOAK_S 9000
`define COOL_S 21600
`define SVC_MAX_S 720000
`define HEAT_MAX_S 7200
`define PURGE_S 600
`define DUTY_WIN_S 100

// register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_HP_THR 8'h04
`define OFS_DUTY_THR 8'h08
`define OFS_PMIN 8'h0c
`define OFS_PMAX 8'h10
`define OFS_LP_THR 8'h14
`define OFS_REGEN_T 8'h18
`define OFS_RELAY_SEL 8'h1c
`define OFS_STATUS 8'h20
`define OFS_MEAS 8'h24
`define OFS_SVC_TIME 8'h28

// reset values; pressure in 0.01 psig, temperature in 0.1 degF
`define RST_HP_THR 16'h0096
`define RST_DUTY_THR 8'h32
`define RST_PMIN 16'h0028
`define RST_PMAX 16'h003c
`define RST_LP_THR 16'h000a
`define RST_REGEN_T 16'h0dac
`define RST_RELAY_SEL 9'h088

// fixed temperature limits, 0.1 degF
`define COLD_LIMIT 16'h0140
`define ENCL_LIMIT 16'h0190
`define WET_DEW 16'hff06
`define COOL_DELTA 16'h00b4

// alarm vector bit positions
`define AL_SUM 0
`define AL_LOWP 1
`define AL_DEW 2
`define AL_HIGHP 3
`define AL_DUTY 4
`define AL_DEAD_A 5
`define AL_DEAD_B 6
`define AL_UNIT 7

// status word field positions
`define ST_SVC_BIT 8
`define ST_SEQ_LSB 9
`define ST_RGN_LSB 11
`define ST_COMP_BIT 14

`endif

// ==== dehy_pkg.sv ====
package dehy_pkg;
  typedef logic signed [15:0] meas_t;
  typedef enum logic [1:0] {
    S_TEST_A = 2'b00,
    S_TEST_B = 2'b01,
    S_RUN = 2'b11
  } seq_e;
  typedef enum logic [2:0] {
    R_IDLE = 3'b000,
    R_HEAT = 3'b001,
    R_SOAK = 3'b011,
    R_PURGE = 3'b010,
    R_COOL = 3'b110
  } regen_e;
endpackage

// ==== dehy_plant.sv ====
`timescale 1ns/1ns
module dehy_plant (
  input wire logic clk, // system clock
  input wire logic heat_a, // canister A heater
  input wire logic heat_b, // canister B heater
  input wire logic [15:0] amb_set, // ambient to present
  input wire logic [15:0] press_set, // pressure to present
  input wire logic [15:0] dew_set, // dew point to present
  output logic [15:0] amb, // ambient sensor
  output logic [15:0] can_a, // canister A housing sensor
  output logic [15:0] can_b, // canister B housing sensor
  output logic [15:0] press, // discharge pressure sensor
  output logic [15:0] dew // discharge dew point sensor
);
  // housings warm 2 degF a clock under heat and drift back to ambient;
  // fast enough to beat the shortened heating timeout and cooling period
  function automatic logic [15:0] step(logic [15:0] t, logic h,
                                      logic [15:0] a);
    if (h) begin
      return t + 16'h0014;
    end
    if (t > a + 16'h0014) begin
      return t - 16'h0014;
    end
    return a;
  endfunction
  initial begin
    amb = 16'h02bc;
    can_a = 16'h02bc;
    can_b = 16'h02bc;
    press = 16'h0032;
    dew = 16'hfe00;
  end
  // five sensors, all level values
  always @(posedge clk) begin
    amb <= amb_set;
    press <= press_set;
    dew <= dew_set;
    can_a <= step(can_a, heat_a, amb_set);
    can_b <= step(can_b, heat_b, amb_set);
  end
endmodule

// ==== dehy_sequencer.sv ====
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "dehy_defines.svh"
// Operation
// [RULE1] high pressure alarm only after pressure above threshold over 30 s
// [RULE2] high pressure threshold resets to 1.5 psig, software may change it
// [RULE3] duty alarm while duty above threshold, threshold resets to 50 %
// [RULE4] duty cycle and discharge pressure readable by software
// [RULE5] compressor held off while internal temperature below 32 degF
// [RULE6] enclosure heater on below 40 degF on weatherproof variant
// [RULE7] three relays, defaults summary, low pressure, dew; source selectable
// [RULE8] relay de-energized on alarm, energized only with no alarm
// [RULE9] regeneration heats to target, soaks 2.5 h, then purges
// [RULE10] canister failing to reach target is marked dead with error
// [RULE11] six hour cool; not within 18 degF of ambient marks unit dead
// [RULE12] wet discharge above -25 degF schedules in-service canister regen
// [RULE13] in-service time counted, regen forced at 200 hours
// [RULE14] power-up: test first, switch to second; first regen if wet
// [RULE15] second tested; if wet first returns, second regenerated
// [RULE16] both wet: second stays in service, first regen, dew alarm
// [RULE17] five sensor inputs: ambient, two canisters, pressure, dew point
// [RULE18] power and summary alarm indicators, status to comms side
// [RULE19] exactly one canister in service at any time
// [RULE20] compressor on below minimum pressure, off at maximum, hold between; purge runs it at any pressure
// [RULE21] persistence timer restarts at or below threshold, alarm clears
// [RULE22] power-up moisture test length is a parameter in clock ticks
module dehy_sequencer
  import dehy_pkg::*;
#(
  parameter int SEC_CYCLES = `CLK_HZ,
  parameter int TEST_CYCLES = `TEST_CYC,
  parameter int SOAK_S = `SOAK_S,
  parameter int COOL_S = `COOL_S,
  parameter int SVC_MAX_S = `SVC_MAX_S,
  parameter int HEAT_MAX_S = `HEAT_MAX_S,
  parameter int PURGE_S = `PURGE_S,
  parameter int DUTY_WIN_S = `DUTY_WIN_S
) (
  input wire logic CORE_CLK, // system clock, 50 MHz
  input wire logic RESET, // async reset, active high
  input wire logic [15:0] AMB_TEMP, // internal ambient, 0.1 degF
  input wire logic [15:0] CAN_A_TEMP, // canister A housing, 0.1 degF
  input wire logic [15:0] CAN_B_TEMP, // canister B housing, 0.1 degF
  input wire logic [15:0] PRESSURE, // discharge, 0.01 psig
  input wire logic [15:0] DEW_POINT, // discharge dew point, 0.1 degF
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WDATA, // register write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after RD
  output logic COMP_ON, // compressor drive
  output logic HEAT_A, // canister A heater
  output logic HEAT_B, // canister B heater
  output logic SVC_VALVE_A, // canister A in service
  output logic SVC_VALVE_B, // canister B in service
  output logic PURGE_VALVE, // purge path open
  output logic ENCL_HEAT, // enclosure heater
  output logic LED_POWER, // power indicator
  output logic LED_ALARM, // summary alarm indicator
  output logic [2:0] RELAY, // relay coils, high = energized
  output logic [7:0] ALARMS // alarm vector to comms side
);
  localparam int SW = $clog2(SEC_CYCLES);
  localparam int TW = $clog2(TEST_CYCLES + 1);
  localparam int XW = $clog2(SVC_MAX_S + 1);

  if (SEC_CYCLES < 2 || TEST_CYCLES < 1 || SOAK_S > SVC_MAX_S ||
      COOL_S > SVC_MAX_S || HEAT_MAX_S > SVC_MAX_S ||
      PURGE_S > SVC_MAX_S || SOAK_S < 1 || COOL_S < 1) begin : g_bad
    $error("timing parameters out of range");
  end

  function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
    return v[s];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // time base and sensor decode

  logic [SW-1:0] div_q;
  logic tick_q;
  meas_t amb, press, dew, rg_temp;
  logic cold, chilly, wet, above_hp;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == SW'(SEC_CYCLES - 1));
      div_q <= (div_q == SW'(SEC_CYCLES - 1)) ? '0 : div_q + SW'(1);
    end
  end

  assign amb = meas_t'(AMB_TEMP); // [RULE17]
  assign press = meas_t'(PRESSURE);
  assign dew = meas_t'(DEW_POINT);
  assign cold = amb < meas_t'(`COLD_LIMIT);
  assign chilly = amb < meas_t'(`ENCL_LIMIT);
  assign wet = dew > meas_t'(`WET_DEW); // [RULE12]

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic ctrl_q;
  logic [15:0] hp_thr_q, pmin_q, pmax_q, lp_thr_q, regen_t_q;
  logic [7:0] duty_thr_q;
  logic [8:0] relay_sel_q;
  logic [7:0] duty_pct;
  logic [31:0] rd_mux;
  seq_e seq_q;
  regen_e rg_q;
  logic svc_q;
  logic [XW-1:0] svc_s_q [2];

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= 1'b0;
      hp_thr_q <= `RST_HP_THR; // [RULE2]
      duty_thr_q <= `RST_DUTY_THR; // [RULE3]
      pmin_q <= `RST_PMIN;
      pmax_q <= `RST_PMAX;
      lp_thr_q <= `RST_LP_THR;
      regen_t_q <= `RST_REGEN_T;
      relay_sel_q <= `RST_RELAY_SEL; // [RULE7]
    end else if (WR) begin
      if (ADDR == `OFS_CTRL) ctrl_q <= WDATA[0];
      if (ADDR == `OFS_HP_THR) hp_thr_q <= WDATA[15:0]; // [RULE2]
      if (ADDR == `OFS_DUTY_THR) duty_thr_q <= WDATA[7:0];
      if (ADDR == `OFS_PMIN) pmin_q <= WDATA[15:0];
      if (ADDR == `OFS_PMAX) pmax_q <= WDATA[15:0];
      if (ADDR == `OFS_LP_THR) lp_thr_q <= WDATA[15:0];
      if (ADDR == `OFS_REGEN_T) regen_t_q <= WDATA[15:0];
      if (ADDR == `OFS_RELAY_SEL) relay_sel_q <= WDATA[8:0]; // [RULE7]
    end
  end

  // unmapped addresses read as zero; read has no side effects
  assign rd_mux =
    (ADDR == `OFS_CTRL) ? {31'h0, ctrl_q} :
    (ADDR == `OFS_HP_THR) ? {16'h0, hp_thr_q} :
    (ADDR == `OFS_DUTY_THR) ? {24'h0, duty_thr_q} :
    (ADDR == `OFS_PMIN) ? {16'h0, pmin_q} :
    (ADDR == `OFS_PMAX) ? {16'h0, pmax_q} :
    (ADDR == `OFS_LP_THR) ? {16'h0, lp_thr_q} :
    (ADDR == `OFS_REGEN_T) ? {16'h0, regen_t_q} :
    (ADDR == `OFS_RELAY_SEL) ? {23'h0, relay_sel_q} :
    (ADDR == `OFS_STATUS) ?
      {17'h0, COMP_ON, rg_q, seq_q, svc_q, ALARMS} : // [RULE18]
    (ADDR == `OFS_MEAS) ? {8'h0, duty_pct, PRESSURE} : // [RULE4]
    (ADDR == `OFS_SVC_TIME) ? 32'(svc_s_q[svc_q]) :
    32'h0;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) RDATA <= 32'h0;
    else RDATA <= RD ? rd_mux : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up test and canister selection

  logic [TW-1:0] tcnt_q;
  logic wet_a_q, both_wet_q;
  logic test_done, svc_due, swap_ok, start_rg, start_can, rg_fin;
  logic [1:0] dead_q;
  logic unit_dead_q;
  logic [XW-1:0] rt_q;
  logic rg_can_q;

  assign test_done = tcnt_q == TW'(TEST_CYCLES - 1); // [RULE22]
  assign svc_due = svc_s_q[svc_q] >= XW'(SVC_MAX_S); // [RULE13]
  // a swap needs an idle regenerator and a healthy standby canister
  assign swap_ok = (seq_q == S_RUN) && (rg_q == R_IDLE) &&
                   !dead_q[!svc_q] && (wet || svc_due); // [RULE12] [RULE13]
  assign start_rg = (seq_q == S_TEST_A && test_done && wet) || // [RULE14]
    (seq_q == S_TEST_B && test_done && wet && !wet_a_q) || // [RULE15]
    swap_ok;
  assign start_can = (seq_q == S_TEST_A) ? 1'b0 :
                     (seq_q == S_TEST_B) ? 1'b1 : svc_q;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      seq_q <= S_TEST_A;
      svc_q <= 1'b0;
      tcnt_q <= '0;
      wet_a_q <= 1'b0;
      both_wet_q <= 1'b0;
    end else begin
      case (seq_q)
        S_TEST_A: begin
          tcnt_q <= test_done ? '0 : tcnt_q + TW'(1);
          if (test_done) begin
            wet_a_q <= wet;
            svc_q <= 1'b1; // [RULE14]
            seq_q <= S_TEST_B;
          end
        end
        S_TEST_B: begin
          tcnt_q <= test_done ? '0 : tcnt_q + TW'(1);
          if (test_done) begin
            seq_q <= S_RUN;
            if (wet && !wet_a_q) svc_q <= 1'b0; // [RULE15]
            if (wet && wet_a_q) both_wet_q <= 1'b1; // [RULE16]
          end
        end
        S_RUN: begin
          if (swap_ok) svc_q <= !svc_q; // [RULE19]
          else if (rg_fin) both_wet_q <= 1'b0;
        end
        default: seq_q <= S_TEST_A;
      endcase
    end
  end

  // in-service time, cleared as a canister leaves for regeneration
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      svc_s_q[0] <= '0;
      svc_s_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (start_rg && start_can == 1'(i)) svc_s_q[i] <= '0;
        else if (tick_q && svc_q == 1'(i) && !(svc_s_q[i] >= XW'(SVC_MAX_S)))
          svc_s_q[i] <= svc_s_q[i] + XW'(1); // [RULE13]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // regeneration of the canister out of service

  logic reached, heat_to, cool_to;

  assign rg_temp = meas_t'(rg_can_q ? CAN_B_TEMP : CAN_A_TEMP);
  assign reached = rg_temp >= meas_t'(regen_t_q);
  assign heat_to = rt_q >= XW'(HEAT_MAX_S);
  assign cool_to = rt_q >= XW'(COOL_S);
  assign rg_fin = (rg_q == R_COOL) && cool_to;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rg_q <= R_IDLE;
      rg_can_q <= 1'b0;
      rt_q <= '0;
      dead_q <= 2'b00;
      unit_dead_q <= 1'b0;
    end else begin
      if (rg_q != R_IDLE && tick_q) rt_q <= rt_q + XW'(1);
      case (rg_q)
        R_IDLE: if (start_rg) begin
          rg_can_q <= start_can;
          rg_q <= R_HEAT;
          rt_q <= '0;
        end
        R_HEAT: if (reached) begin // [RULE9]
          rg_q <= R_SOAK;
          rt_q <= '0;
        end else if (heat_to) begin
          dead_q[rg_can_q] <= 1'b1; // [RULE10]
          rg_q <= R_IDLE;
        end
        R_SOAK: if (rt_q >= XW'(SOAK_S)) begin // [RULE9]
          rg_q <= R_PURGE;
          rt_q <= '0;
        end
        R_PURGE: if (rt_q >= XW'(PURGE_S)) begin
          rg_q <= R_COOL;
          rt_q <= '0;
        end
        R_COOL: if (cool_to) begin
          // signed delta; a canister still hot after six hours kills the unit
          if (rg_temp - amb >= meas_t'(`COOL_DELTA))
            unit_dead_q <= 1'b1; // [RULE11]
          rg_q <= R_IDLE;
        end
        default: rg_q <= R_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pressure control and alarms

  logic hyst_q;
  logic [5:0] hp_q;
  logic heat_on, comp_d;
  logic [7:0] al_w;

  assign above_hp = press > meas_t'(hp_thr_q);
  // purge borrows the compressor; cold inhibit still wins over it
  assign comp_d = (hyst_q || rg_q == R_PURGE) && !cold; // [RULE5]
  assign heat_on = (rg_q == R_HEAT) || (rg_q == R_SOAK && !reached);

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      hyst_q <= 1'b0;
      hp_q <= 6'h00;
    end else begin
      if (press < meas_t'(pmin_q)) hyst_q <= 1'b1; // [RULE20]
      else if (press >= meas_t'(pmax_q)) hyst_q <= 1'b0;
      if (!above_hp) hp_q <= 6'h00; // [RULE21]
      else if (tick_q && hp_q <= 6'(`HP_PERSIST_S)) hp_q <= hp_q + 6'h01;
    end
  end

  assign al_w[`AL_LOWP] = press < meas_t'(lp_thr_q);
  assign al_w[`AL_DEW] = (seq_q == S_RUN && wet) || both_wet_q; // [RULE16]
  assign al_w[`AL_HIGHP] = above_hp && (hp_q > 6'(`HP_PERSIST_S)); // [RULE1]
  assign al_w[`AL_DUTY] = duty_pct > duty_thr_q; // [RULE3]
  assign al_w[`AL_DEAD_A] = dead_q[0]; // [RULE10]
  assign al_w[`AL_DEAD_B] = dead_q[1];
  assign al_w[`AL_UNIT] = unit_dead_q; // [RULE11]
  assign al_w[`AL_SUM] = |al_w[7:1];

  duty_meter #(
    .WIN_S(DUTY_WIN_S)
  ) u_duty (
    .clk(CORE_CLK),
    .rst(RESET),
    .sec_tick(tick_q),
    .comp_on(COMP_ON),
    .duty_pct(duty_pct) // [RULE4]
  );

  ////////////////////////////////////////////////////////////////////////
  // output flops

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      COMP_ON <= 1'b0;
      HEAT_A <= 1'b0;
      HEAT_B <= 1'b0;
      SVC_VALVE_A <= 1'b1;
      SVC_VALVE_B <= 1'b0;
      PURGE_VALVE <= 1'b0;
      ENCL_HEAT <= 1'b0;
      LED_POWER <= 1'b0;
      LED_ALARM <= 1'b0;
      RELAY <= 3'h0;
      ALARMS <= 8'h00;
    end else begin
      COMP_ON <= comp_d; // [RULE5] [RULE20]
      HEAT_A <= heat_on && !rg_can_q;
      HEAT_B <= heat_on && rg_can_q;
      SVC_VALVE_A <= !svc_q; // [RULE19]
      SVC_VALVE_B <= svc_q;
      PURGE_VALVE <= rg_q == R_PURGE; // [RULE9]
      ENCL_HEAT <= ctrl_q && chilly; // [RULE6]
      LED_POWER <= 1'b1; // [RULE18]
      LED_ALARM <= al_w[`AL_SUM];
      // coil drops on alarm, so an alarm looks like loss of power
      for (int i = 0; i < 3; i++)
        RELAY[i] <= !pick(al_w, relay_sel_q[3*i +: 3]); // [RULE8]
      ALARMS <= al_w; // [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence soak_to_purge;
    rg_q == R_SOAK ##1 rg_q == R_PURGE;
  endsequence
  sequence test_a_to_b;
    seq_q == S_TEST_A ##1 seq_q == S_TEST_B;
  endsequence

  a_hp_persist: assert property ($rose(ALARMS[`AL_HIGHP]) |-> // [RULE1]
    $past(above_hp, 2) && $past(hp_q) == 6'(`HP_PERSIST_S + 1))
    else $error("high pressure alarm without persistence");
  a_hp_default: assert property ($past(RESET) |-> // [RULE2]
    hp_thr_q == `RST_HP_THR)
    else $error("high pressure threshold not at default");
  a_duty_alarm: assert property ((duty_pct > duty_thr_q) |=> // [RULE3]
    ALARMS[`AL_DUTY])
    else $error("duty alarm missing");
  a_meas_read: assert property ((RD && ADDR == `OFS_MEAS) |=> // [RULE4]
    RDATA == {8'h0, $past(duty_pct), $past(PRESSURE)})
    else $error("measurement readback wrong");
  a_cold_comp: assert property (cold |=> !COMP_ON) // [RULE5]
    else $error("compressor on while cold");
  a_encl_heat: assert property ((ctrl_q && chilly) |=> ENCL_HEAT) // [RULE6]
    else $error("enclosure heater off while chilly");
  a_relay_drop: assert property (pick(al_w, relay_sel_q[2:0]) |=> // [RULE8]
    !RELAY[0])
    else $error("relay energized during alarm");
  a_soak_time: assert property (soak_to_purge |-> // [RULE9]
    $past(rt_q) >= XW'(SOAK_S))
    else $error("soak ended early");
  a_heat_dead: assert property ((rg_q == R_HEAT && heat_to && // [RULE10]
    !reached) |=> dead_q[$past(rg_can_q)] && rg_q == R_IDLE)
    else $error("dead canister not flagged");
  a_both_wet: assert property ((seq_q == S_TEST_B && test_done && // [RULE16]
    wet && wet_a_q) |=> svc_q && both_wet_q ##1 ALARMS[`AL_DEW])
    else $error("both wet handling wrong");
  a_one_service: assert property (SVC_VALVE_A != SVC_VALVE_B) // [RULE19]
    else $error("service valves not exclusive");
  a_comp_low: assert property (((press < meas_t'(pmin_q)) && !cold) ##1 // [RULE20]
    !cold |=> COMP_ON)
    else $error("compressor not started at low pressure");
  a_hp_restart: assert property (!above_hp |=> // [RULE21]
    hp_q == 6'h00 && !ALARMS[`AL_HIGHP])
    else $error("high pressure timer not restarted");
  a_test_len: assert property (test_a_to_b |-> // [RULE22]
    $past(tcnt_q) == TW'(TEST_CYCLES - 1))
    else $error("power-up test length wrong");
endmodule

// ==== duty_meter.sv ====
`timescale 1ns/1ns
`include "dehy_defines.svh"
module duty_meter #(
  parameter int WIN_S = `DUTY_WIN_S
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic sec_tick, // one pulse per second
  input wire logic comp_on, // compressor running
  output logic [7:0] duty_pct // last window duty, percent
);
  localparam int CW = $clog2(WIN_S + 1);
  logic [CW-1:0] win_q;
  logic [CW-1:0] on_q;
  logic win_end;
  logic [31:0] pct_w;

  if (WIN_S < 1 || WIN_S > 65535) begin : g_bad_win
    $error("duty window out of range");
  end

  // sampled once per second: coarse, but cheap and plenty for a duty ratio
  assign win_end = sec_tick && (win_q == CW'(WIN_S - 1));
  assign pct_w = ((32'(on_q) + 32'(comp_on)) * 32'd100) / 32'(WIN_S);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_q <= '0;
      on_q <= '0;
      duty_pct <= 8'h00;
    end else if (win_end) begin
      win_q <= '0;
      on_q <= '0;
      duty_pct <= pct_w[7:0];
    end else if (sec_tick) begin
      win_q <= win_q + CW'(1);
      on_q <= on_q + CW'(comp_on);
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  import dehy_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [15:0] amb_set = 16'h02bc;
  logic [15:0] press_set = 16'h0032;
  logic [15:0] dew_set = 16'hfe00;
  logic [15:0] amb, can_a, can_b, press, dew;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA, rv;
  logic COMP_ON, HEAT_A, HEAT_B, SVC_VALVE_A, SVC_VALVE_B, PURGE_VALVE;
  logic ENCL_HEAT, LED_POWER, LED_ALARM;
  logic [2:0] RELAY;
  logic [7:0] ALARMS;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  dehy_plant plant (.clk(CORE_CLK), .heat_a(HEAT_A), .heat_b(HEAT_B),
    .amb_set(amb_set), .press_set(press_set), .dew_set(dew_set),
    .amb(amb), .can_a(can_a), .can_b(can_b), .press(press), .dew(dew));
  // one second is ten clocks so the long timers fit the run
  localparam int T_SEC = 10;
  localparam int T_TEST = 2 * T_SEC;
  localparam int T_SOAK = 5;
  localparam int T_COOL = 2 * T_SEC;
  localparam int T_SVC = 30 * T_SEC;
  localparam int T_HEAT = 2 * T_SEC;
  localparam int T_PURGE = 3;
  localparam int T_DUTY = T_SEC;
  dehy_sequencer #(.SEC_CYCLES(T_SEC), .TEST_CYCLES(T_TEST),
    .SOAK_S(T_SOAK), .COOL_S(T_COOL), .SVC_MAX_S(T_SVC),
    .HEAT_MAX_S(T_HEAT), .PURGE_S(T_PURGE),
    .DUTY_WIN_S(T_DUTY)) dut (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .AMB_TEMP(amb), .CAN_A_TEMP(can_a), .CAN_B_TEMP(can_b),
    .PRESSURE(press), .DEW_POINT(dew), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .COMP_ON(COMP_ON), .HEAT_A(HEAT_A),
    .HEAT_B(HEAT_B), .SVC_VALVE_A(SVC_VALVE_A), .SVC_VALVE_B(SVC_VALVE_B),
    .PURGE_VALVE(PURGE_VALVE), .ENCL_HEAT(ENCL_HEAT),
    .LED_POWER(LED_POWER), .LED_ALARM(LED_ALARM), .RELAY(RELAY),
    .ALARMS(ALARMS));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge CORE_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic sense(logic [15:0] a, logic [15:0] p, logic [15:0] d);
    @(posedge CORE_CLK);
    amb_set <= a;
    press_set <= p;
    dew_set <= d;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    chk(SVC_VALVE_A, 1'b1);
    RESET <= 1'b0;
    rd(8'h04, rv);
    chk(rv, 32'h96);
    rd(8'h08, rv);
    chk(rv, 32'h32);
    rd(8'h1c, rv);
    chk(rv, 32'h88);
    rd(8'hfc, rv);
    chk(rv, 32'h0);
    rd(8'h20, rv);
    chk(rv[10:9], 2'b00);
    tick(40);
    chk({SVC_VALVE_A, SVC_VALVE_B}, 2'b01);
    chk(LED_POWER, 1'b1);
    rd(8'h20, rv);
    chk(rv[10:8], 3'b111);
  endtask
  task automatic t_compressor();
    sense(16'h012c, 16'h000a, 16'hfe00);
    tick(6);
    chk(COMP_ON, 1'b0);
    chk(ENCL_HEAT, 1'b0);
    sense(16'h02bc, 16'h000a, 16'hfe00);
    tick(6);
    chk(COMP_ON, 1'b1);
    sense(16'h02bc, 16'h0005, 16'hfe00);
    tick(4);
    chk({ALARMS[1], RELAY[1:0], LED_ALARM}, 4'b1001);
    sense(16'h02bc, 16'h0032, 16'hfe00);
    tick(6);
    chk(COMP_ON, 1'b1);
    sense(16'h02bc, 16'h003c, 16'hfe00);
    tick(6);
    chk(COMP_ON, 1'b0);
    sense(16'h02bc, 16'h0032, 16'hfe00);
    tick(6);
    chk(COMP_ON, 1'b0);
    wr(8'h00, 32'h1);
    sense(16'h015e, 16'h0032, 16'hfe00);
    tick(4);
    chk(ENCL_HEAT, 1'b1);
    sense(16'h01c2, 16'h0032, 16'hfe00);
    tick(4);
    chk(ENCL_HEAT, 1'b0);
  endtask
  task automatic t_high_press();
    wr(8'h1c, 32'h0c8);
    sense(16'h02bc, 16'h00c8, 16'hfe00);
    tick(200);
    sense(16'h02bc, 16'h0096, 16'hfe00);
    tick(2);
    sense(16'h02bc, 16'h00c8, 16'hfe00);
    tick(280);
    chk(ALARMS[3], 1'b0);
    tick(50);
    chk({ALARMS[3], RELAY[2], LED_ALARM}, 3'b101);
    rd(8'h24, rv);
    chk(rv[15:0], 16'h00c8);
    sense(16'h02bc, 16'h0064, 16'hfe00);
    tick(4);
    chk({ALARMS[3], RELAY[2]}, 2'b01);
  endtask
  task automatic t_duty();
    wr(8'h08, 32'h0);
    sense(16'h02bc, 16'h000a, 16'hfe00);
    tick(250);
    chk(ALARMS[4], 1'b1);
    rd(8'h24, rv);
    chk(rv, 32'h0064000a);
    wr(8'h08, 32'h32);
    sense(16'h02bc, 16'h003c, 16'hfe00);
    tick(250);
    chk(ALARMS[4], 1'b0);
  endtask
  task automatic t_wet_regen();
    int i;
    sense(16'h02bc, 16'h0032, 16'hff38);
    tick(5);
    chk({SVC_VALVE_A, SVC_VALVE_B, HEAT_B, ALARMS[2]}, 4'b1011);
    sense(16'h02bc, 16'h0032, 16'hfe00);
    for (i = 0; i < 500 && PURGE_VALVE !== 1'b1; i++) begin
      tick(1);
    end
    chk({PURGE_VALVE, HEAT_B}, 2'b10);
    tick(300);
    chk(ALARMS[7:5], 3'b000);
    rd(8'h20, rv);
    chk(rv[13:11], 3'b000);
    for (i = 0; i < 3200 && SVC_VALVE_B !== 1'b1; i++) begin
      tick(1);
    end
    tick(2);
    chk({SVC_VALVE_A, SVC_VALVE_B, HEAT_A}, 3'b011);
  endtask
  task automatic t_both_wet();
    @(posedge CORE_CLK);
    RESET <= 1'b1;
    sense(16'h02bc, 16'h0032, 16'hff38);
    tick(2);
    chk({SVC_VALVE_A, COMP_ON}, 2'b10);
    @(posedge CORE_CLK);
    RESET <= 1'b0;
    tick(44);
    chk({SVC_VALVE_B, HEAT_A, ALARMS[2]}, 3'b111);
  endtask
  initial begin
    tick(6);
    t_reset_vals();
    t_compressor();
    t_high_press();
    t_duty();
    t_wet_regen();
    t_both_wet();
    report_and_stop();
  end
endmodule
